/* shared/wqr_pkg.sv */
// Constants and carriers for the watchdog, Q&A and interrupt register slice.
// Assumes an 8-bit register port in front of it on the device clock.
package wqr_pkg;

   // ***********************************************************************
   // Register offsets
   // ***********************************************************************
   localparam logic [7:0] OFS_WATCHDOG_KICK   = 8'h15;
   localparam logic [7:0] OFS_QA_CONFIG       = 8'h2d;
   localparam logic [7:0] OFS_QA_ANSWER       = 8'h2e;
   localparam logic [7:0] OFS_QA_QUESTION     = 8'h2f;
   localparam logic [7:0] OFS_XCVR_STATE      = 8'h40;
   localparam logic [7:0] OFS_INT_SUMMARY     = 8'h50;
   localparam logic [7:0] OFS_WAKE_BUS_FLAGS  = 8'h51;

   // ***********************************************************************
   // Reset values and fixed values
   // ***********************************************************************
   localparam logic [7:0] RST_QA_CONFIG       = 8'h00;
   localparam logic [7:0] RST_QA_ANSWER       = 8'h00;
   localparam logic [7:0] RST_FLAGS           = 8'h00;
   localparam logic [7:0] RST_RDATA           = 8'h00;
   localparam logic [7:0] KICK_VALUE          = 8'hff;
   localparam logic [3:0] SEED_POWERUP        = 4'h5;
   localparam logic [3:0] QUESTION_ENABLED    = 4'hc;
   localparam logic [1:0] ANSWER_CNT_ENABLED  = 2'h3;

   // ***********************************************************************
   // Field positions
   // ***********************************************************************
   localparam int ANSWER_GEN_LSB    = 6;
   localparam int POLY_SETTING_LSB  = 4;
   localparam int POLY_SEED_LSB     = 0;
   localparam int ANSWER_ERR_BIT    = 6;
   localparam int CAN_ACTIVE_BIT    = 3;
   localparam int BUS_SILENCE_BIT   = 2;
   localparam int TXD_BLOCK_BIT     = 0;
   localparam int SUM_ANY_BIT       = 7;
   localparam int SUM_INT1_BIT      = 6;
   localparam int SUM_INT2_BIT      = 5;
   localparam int SUM_INT3_BIT      = 4;
   localparam int SUM_BUS_BIT       = 3;
   localparam int WD_EVENT_BIT      = 7;
   localparam int BUS_WAKE_BIT      = 6;
   localparam int LOCAL_WAKE_BIT    = 5;
   localparam int WAKE_ERR_BIT      = 4;
   localparam int BUS_SILENT_BIT    = 2;
   localparam int STUCK_DOM_BIT     = 0;
   localparam logic [7:0] FLAGS_VALID = 8'hf5;

   // ***********************************************************************
   // Watchdog mode codes
   // ***********************************************************************
   localparam logic [1:0] MODE_AUTONOMOUS = 2'h0;
   localparam logic [1:0] MODE_TIMEOUT    = 2'h1;
   localparam logic [1:0] MODE_WINDOW     = 2'h2;
   localparam logic [1:0] MODE_QA         = 2'h3;

   // ***********************************************************************
   // Carriers
   // ***********************************************************************
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } wqr_reg_req_t;

   // One bit per flag, in wake_and_bus_flags bit order, then answer_error from the question register
   typedef struct packed {
      logic watchdog_error;
      logic bus_wake;
      logic local_wake;
      logic wake_timer_sleep;
      logic bus_silent;
      logic stuck_dominant;
      logic answer_error;
   } wqr_events_t;

   typedef struct packed {
      logic       can_active;
      logic       bus_silence;
      logic       transmit_low_block;
      logic       int2_any;
      logic       int3_any;
      logic       bus_fault_any;
   } wqr_status_t;

   typedef struct packed {
      logic [7:0] config_q;
      logic       seed_written;
      logic       seed_load;
      logic [7:0] answer_byte;
      logic       answer_strobe;
      logic       answer_error_flag;
      logic [7:0] flags;
      logic [7:0] summary;
      logic       kick;
      logic [7:0] rdata;
      logic       rvalid;
      logic       int_req;
   } wqr_state_t;

endpackage

/* core/wqr_regs.sv */
// Watchdog kick, Q&A watchdog and first interrupt register slice.
// Assumes the serial port logic hands over decoded byte accesses on
// core_clk_i; watchdog engine and other flag registers sit outside.
`timescale 1ns/1ps

// Function
// - Writing FF to kick register pulses kick
// - Q&A config holds three read/write fields
// - Seed presented to generator during reset state
// - Seed reads zero, uses 101b until written
// - Answer byte stored for evaluation
// - Question reads C while watchdog enabled
// - Answer count reads 3 while enabled
// - Answer error flag, write one clears
// - Status bit 3 shows transceiver active
// - Status bit 2 shows bus silence
// - Status bit 0 shows transmit-low block
// - Summary bit 7 ORs summary bits 6..3
// - Summary bits 6..3 OR each register
// - Watchdog, bus and local wake flags, W1C
// - Silent and stuck flags W1C; reserved zero
// - Every watchdog error sets event flag
// - Wake error on timer expiry in sleep
// - Mode codes; answer strobe and answer error only in Q&A
// - Enable bits, default one, gate interrupt
module wqr_regs
   import wqr_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   // Clock and reset
   input  wire logic         core_clk_i,
   input  wire logic         rst_n_i,
   // Register port
   input  wire wqr_reg_req_t reg_req_i,
   output logic [7:0]        reg_rdata_o,
   output logic              reg_rvalid_o,
   // Watchdog engine side
   input  wire logic         watchdog_enabled_i,
   input  wire logic [1:0]   watchdog_mode_field_i,
   input  wire logic         device_in_reset_i,
   output logic              watchdog_kick_o,
   output logic [3:0]        polynomial_seed_o,
   output logic              seed_load_o,
   output logic [1:0]        answer_generation_setting_o,
   output logic [1:0]        polynomial_setting_o,
   output logic [7:0]        answer_byte_o,
   output logic              answer_strobe_o,
   // Events, status and interrupt
   input  wire wqr_events_t  events_i,
   input  wire wqr_status_t  status_i,
   input  wire logic [7:0]   watchdog_event_mask_i,
   output logic              any_interrupt_summary_o,
   output logic              int_request_o
);

   // ***********************************************************************
   // Elaboration checks
   // ***********************************************************************
   // Offsets reach 0x51 on the 8-bit address, so ADDR_W must be exactly 8
   if (ADDR_W != 8) begin : g_bad_addr
      $error("wqr_regs: ADDR_W must be 8");
   end

   wqr_state_t st;
   wqr_state_t next_st;

   logic       wr_kick;
   logic       wr_cfg;
   logic       wr_ans;
   logic       wr_q;
   logic       wr_flags;
   logic       qa_mode;
   logic [7:0] set_flags;
   logic [7:0] question_rd;
   logic [7:0] status_rd;
   logic [7:0] rd_mux;

   // ***********************************************************************
   // Decode and combinational views
   // ***********************************************************************
   always_comb begin
      wr_kick  = reg_req_i.wr && reg_req_i.addr == OFS_WATCHDOG_KICK;
      wr_cfg   = reg_req_i.wr && reg_req_i.addr == OFS_QA_CONFIG;
      wr_ans   = reg_req_i.wr && reg_req_i.addr == OFS_QA_ANSWER;
      wr_q     = reg_req_i.wr && reg_req_i.addr == OFS_QA_QUESTION;
      wr_flags = reg_req_i.wr && reg_req_i.addr == OFS_WAKE_BUS_FLAGS;
      qa_mode  = watchdog_mode_field_i == MODE_QA;
      set_flags = 8'h00;
      set_flags[WD_EVENT_BIT]   = events_i.watchdog_error;
      set_flags[BUS_WAKE_BIT]   = events_i.bus_wake;
      set_flags[LOCAL_WAKE_BIT] = events_i.local_wake;
      set_flags[WAKE_ERR_BIT]   = events_i.wake_timer_sleep;
      set_flags[BUS_SILENT_BIT] = events_i.bus_silent;
      set_flags[STUCK_DOM_BIT]  = events_i.stuck_dominant;
      question_rd = 8'h00;
      question_rd[ANSWER_ERR_BIT] = st.answer_error_flag;
      if (watchdog_enabled_i) begin
         question_rd[3:0] = QUESTION_ENABLED;
         question_rd[5:4] = ANSWER_CNT_ENABLED;
      end
      status_rd = 8'h00;
      status_rd[CAN_ACTIVE_BIT]  = status_i.can_active;
      status_rd[BUS_SILENCE_BIT] = status_i.bus_silence;
      status_rd[TXD_BLOCK_BIT]   = status_i.transmit_low_block;
      unique case (reg_req_i.addr)
         OFS_QA_CONFIG:      rd_mux = st.config_q;
         OFS_QA_ANSWER:      rd_mux = st.answer_byte;
         OFS_QA_QUESTION:    rd_mux = question_rd;
         OFS_XCVR_STATE:     rd_mux = status_rd;
         OFS_INT_SUMMARY:    rd_mux = st.summary;
         OFS_WAKE_BUS_FLAGS: rd_mux = st.flags;
         // Kick register and unmapped offsets read zero
         default:            rd_mux = 8'h00;
      endcase
   end

   // ***********************************************************************
   // Next state
   // ***********************************************************************
   always_comb begin
      next_st = st;
      next_st.kick = wr_kick && reg_req_i.wdata == KICK_VALUE;
      if (wr_cfg) begin
         next_st.config_q     = reg_req_i.wdata;
         next_st.seed_written = 1'b1;
      end
      next_st.seed_load = device_in_reset_i;
      if (wr_ans) begin
         next_st.answer_byte = reg_req_i.wdata;
      end
      next_st.answer_strobe = wr_ans && qa_mode;
      // Set wins over a same-cycle clear so no event is lost
      if (events_i.answer_error && qa_mode) begin
         next_st.answer_error_flag = 1'b1;
      end else if (wr_q && reg_req_i.wdata[ANSWER_ERR_BIT]) begin
         next_st.answer_error_flag = 1'b0;
      end
      if (wr_flags) begin
         next_st.flags = st.flags & ~reg_req_i.wdata;
      end
      next_st.flags = (next_st.flags | set_flags) & FLAGS_VALID;
      // Built from next flags so the summary never lags them
      next_st.summary = 8'h00;
      next_st.summary[SUM_INT1_BIT] = |next_st.flags;
      next_st.summary[SUM_INT2_BIT] = status_i.int2_any;
      next_st.summary[SUM_INT3_BIT] = status_i.int3_any;
      next_st.summary[SUM_BUS_BIT]  = status_i.bus_fault_any;
      next_st.summary[SUM_ANY_BIT]  = |next_st.summary[6:3];
      next_st.int_req = |(next_st.flags & watchdog_event_mask_i);
      next_st.rvalid  = reg_req_i.rd;
      if (reg_req_i.rd) begin
         next_st.rdata = rd_mux;
      end
   end

   // ***********************************************************************
   // State register
   // ***********************************************************************
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         st                   <= '0;
         st.config_q          <= RST_QA_CONFIG;
         st.answer_byte       <= RST_QA_ANSWER;
         st.flags             <= RST_FLAGS;
         st.rdata             <= RST_RDATA;
      end else begin
         st <= next_st;
      end
   end

   // ***********************************************************************
   // Outputs
   // ***********************************************************************
   assign reg_rdata_o                 = st.rdata;
   assign reg_rvalid_o                = st.rvalid;
   assign watchdog_kick_o             = st.kick;
   // Unwritten seed field reads zero yet 101b drives the generator
   assign polynomial_seed_o           = st.seed_written ?
                                        st.config_q[3:0] : SEED_POWERUP;
   assign seed_load_o                 = st.seed_load;
   assign answer_generation_setting_o = st.config_q[7:6];
   assign polynomial_setting_o        = st.config_q[5:4];
   assign answer_byte_o               = st.answer_byte;
   assign answer_strobe_o             = st.answer_strobe;
   assign any_interrupt_summary_o     = st.summary[SUM_ANY_BIT];
   assign int_request_o               = st.int_req;

   // ***********************************************************************
   // Assertions
   // ***********************************************************************
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!rst_n_i);

   sequence s_write(logic [7:0] a);
      reg_req_i.wr && reg_req_i.addr == a;
   endsequence
   sequence s_read(logic [7:0] a);
      reg_req_i.rd && reg_req_i.addr == a;
   endsequence

   kick_on_ff_a: assert property (
      s_write(OFS_WATCHDOG_KICK) ##0 (reg_req_i.wdata == KICK_VALUE)
      |=> watchdog_kick_o ##1 !watchdog_kick_o || $past(reg_req_i.wr))
      else $error("Kick missing after FF write");
   kick_only_ff_a: assert property (
      !(wr_kick && reg_req_i.wdata == KICK_VALUE) |=> !watchdog_kick_o)
      else $error("Kick without FF write");
   config_readback_a: assert property (
      s_write(OFS_QA_CONFIG) ##1 !wr_cfg
      ##1 (s_read(OFS_QA_CONFIG) ##0 !wr_cfg)
      |=> reg_rdata_o == $past(reg_req_i.wdata, 3) && reg_rvalid_o)
      else $error("Config read back wrong");
   seed_use_a: assert property (
      st.seed_written ? polynomial_seed_o == st.config_q[3:0]
                      : polynomial_seed_o == SEED_POWERUP)
      else $error("Seed in use wrong");
   seed_load_a: assert property (
      device_in_reset_i |=> seed_load_o)
      else $error("Seed not loaded in reset state");
   answer_hold_a: assert property (
      s_write(OFS_QA_ANSWER) ##1 !wr_ans [*2]
      |-> answer_byte_o == $past(reg_req_i.wdata, 2))
      else $error("Answer byte not held");
   question_en_a: assert property (
      s_read(OFS_QA_QUESTION) && watchdog_enabled_i
      |=> reg_rdata_o[5:0] == 6'h3c)
      else $error("Question or count wrong while enabled");
   answer_err_a: assert property (
      events_i.answer_error && qa_mode |=> st.answer_error_flag)
      else $error("Answer error lost");
   answer_clear_a: assert property (
      wr_q && reg_req_i.wdata[ANSWER_ERR_BIT]
      && !(events_i.answer_error && qa_mode) |=> !st.answer_error_flag)
      else $error("Answer error not cleared");
   status_read_a: assert property (
      s_read(OFS_XCVR_STATE) |=> reg_rdata_o ==
      {4'h0, $past(status_i.can_active), $past(status_i.bus_silence),
       1'b0, $past(status_i.transmit_low_block)})
      else $error("Status read wrong");
   summary_follow_a: assert property (
      st.summary[SUM_ANY_BIT] == (|st.summary[6:3])
      && st.summary[SUM_INT1_BIT] == (|st.flags))
      else $error("Summary out of step with flags");
   wd_flag_a: assert property (
      events_i.watchdog_error |=> st.flags[WD_EVENT_BIT])
      else $error("Watchdog event flag not set");
   clear_flags_a: assert property (
      s_write(OFS_WAKE_BUS_FLAGS) ##0 (set_flags == 8'h00)
      |=> (st.flags & $past(reg_req_i.wdata)) == 8'h00)
      else $error("Flag not cleared by write one");
   int_gate_a: assert property (
      int_request_o == |(st.flags & $past(watchdog_event_mask_i)))
      else $error("Interrupt request mismatch");

endmodule

/* test/wqr_host_model.sv */
// Host side model of the byte strobe register port.
// Assumes the bench calls wr_reg and rd_reg only after reset release.
`timescale 1ns/1ps
module wqr_host_model
   import wqr_pkg::*;
(
   // Clock
   input  wire logic         core_clk_i,
   // Register port
   output wqr_reg_req_t      req_o,
   input  wire logic [7:0]   rdata_i,
   input  wire logic         rvalid_i
);
   // ****************************************
   // Access tasks
   // ****************************************
   initial begin
      req_o = '0;
   end

   // Address inverted on release so stale values never match by luck
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(negedge core_clk_i);
      req_o = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(negedge core_clk_i);
      req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
   endtask

   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      @(negedge core_clk_i);
      req_o = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(negedge core_clk_i);
      d = (rvalid_i === 1'b1) ? rdata_i : 8'hxx;
      req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hff};
   endtask
endmodule

/* test/wqr_regs_test.sv */
// Self-checking bench for the watchdog, Q&A and flag register slice.
// Assumes the host model makes every register access.
`timescale 1ns/1ps
module wqr_regs_test
   import wqr_pkg::*;
;
   logic         core_clk_i = 1'b0;
   logic         rst_n_i = 1'b0;
   wqr_reg_req_t req;
   logic [7:0]   rdata, ans, mask, got;
   logic         rvalid, wd_en, in_rst, kick, sload, strobe, any_sum, irq;
   logic [1:0]   mode, agen, pset;
   logic [3:0]   seed;
   wqr_events_t  ev;
   wqr_status_t  st;
   int           err_total = 0;
   int           total_checks = 0;
   int           cycles = 0;
   int           kicks = 0;
   logic [7:0]   offs [8] = '{8'h15, 8'h2d, 8'h2e, 8'h2f, 8'h40, 8'h50,
                              8'h51, 8'h33};
   logic [7:0]   e40 [6] = '{8'h08, 8'h04, 8'h01, 8'h00, 8'h00, 8'h00};
   logic [7:0]   e50 [6] = '{8'h00, 8'h00, 8'h00, 8'ha0, 8'h90, 8'h88};
   logic [7:0]   fl [6] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h04, 8'h01};

   wqr_host_model u_host (
      .core_clk_i (core_clk_i),
      .req_o      (req),
      .rdata_i    (rdata),
      .rvalid_i   (rvalid)
   );

   wqr_regs u_dut (
      .core_clk_i                  (core_clk_i),
      .rst_n_i                     (rst_n_i),
      .reg_req_i                   (req),
      .reg_rdata_o                 (rdata),
      .reg_rvalid_o                (rvalid),
      .watchdog_enabled_i          (wd_en),
      .watchdog_mode_field_i       (mode),
      .device_in_reset_i           (in_rst),
      .watchdog_kick_o             (kick),
      .polynomial_seed_o           (seed),
      .seed_load_o                 (sload),
      .answer_generation_setting_o (agen),
      .polynomial_setting_o        (pset),
      .answer_byte_o               (ans),
      .answer_strobe_o             (strobe),
      .events_i                    (ev),
      .status_i                    (st),
      .watchdog_event_mask_i       (mask),
      .any_interrupt_summary_o     (any_sum),
      .int_request_o               (irq)
   );

   // ****************************************
   // Clock, timeout and helpers
   // ****************************************
   always #5 core_clk_i = ~core_clk_i;

   // Whole run is under two hundred cycles
   always @(negedge core_clk_i) begin
      cycles++;
      if (kick === 1'b1) kicks++;
      if (cycles > 3000) begin
         err_total++;
         print_verdict();
      end
   end

   task automatic print_verdict();
      if (err_total == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic chk(input string n, input logic [7:0] e,
                      input logic [7:0] g);
      total_checks++;
      if (g !== e) begin
         err_total++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      u_host.rd_reg(a, got);
      chk($sformatf("reg %h", a), e, got);
   endtask

   task automatic pulse(input wqr_events_t e);
      @(negedge core_clk_i);
      ev = e;
      @(negedge core_clk_i);
      ev = '0;
   endtask

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      ev = '0;
      st = '0;
      wd_en = 1'b0;
      in_rst = 1'b0;
      mode = MODE_QA;
      mask = 8'hf5;
      repeat (10) @(negedge core_clk_i);
      rst_n_i = 1'b1;
      foreach (offs[i]) rchk(offs[i], 8'h00);
      chk("seed in use", 8'h05, {4'h0, seed});
      u_host.wr_reg(8'h2d, 8'ha7);
      rchk(8'h2d, 8'ha7);
      chk("seed in use", 8'h07, {4'h0, seed});
      chk("gen and poly", 8'h0a, {4'h0, agen, pset});
      in_rst = 1'b1;
      repeat (2) @(negedge core_clk_i);
      chk("seed load", 8'h01, {7'h00, sload});
      in_rst = 1'b0;
      u_host.wr_reg(8'h2e, 8'h5a);
      chk("answer strobe", 8'h01, {7'h00, strobe});
      rchk(8'h2e, 8'h5a);
      chk("answer byte", 8'h5a, ans);
      u_host.wr_reg(8'h15, 8'hfe);
      u_host.wr_reg(8'h15, 8'hff);
      @(negedge core_clk_i);
      chk("kick count", 8'h01, kicks[7:0]);
      rchk(8'h15, 8'h00);
      wd_en = 1'b1;
      rchk(8'h2f, 8'h3c);
      // Answer error only counts in Q&A mode
      for (int m = 0; m < 4; m++) begin
         mode = 2'(m);
         pulse(wqr_events_t'(7'h01));
         rchk(8'h2f, (m == 3) ? 8'h7c : 8'h3c);
         u_host.wr_reg(8'h2f, 8'h40);
         rchk(8'h2f, 8'h3c);
         u_host.wr_reg(8'h2e, 8'h11);
         chk("answer strobe", {7'h00, m == 3}, {7'h00, strobe});
      end
      for (int i = 0; i < 6; i++) begin
         st = wqr_status_t'(6'(1 << (5 - i)));
         rchk(8'h40, e40[i]);
         rchk(8'h50, e50[i]);
      end
      st = '0;
      for (int i = 0; i < 6; i++) begin
         pulse(wqr_events_t'(7'(2 << (5 - i))));
         rchk(8'h51, fl[i]);
         rchk(8'h50, 8'hc0);
         chk("irq and summary", 8'h03, {6'h00, irq, any_sum});
         u_host.wr_reg(8'h51, fl[i]);
         rchk(8'h51, 8'h00);
         rchk(8'h50, 8'h00);
      end
      mask = 8'h00;
      pulse(wqr_events_t'(7'h40));
      chk("masked irq", 8'h00, {7'h00, irq});
      mask = 8'hf5;
      @(negedge core_clk_i);
      chk("unmasked irq", 8'h01, {7'h00, irq});
      u_host.wr_reg(8'h51, 8'hff);
      rchk(8'h51, 8'h00);
      u_host.wr_reg(8'h40, 8'hff);
      rchk(8'h40, 8'h00);
      print_verdict();
   end
endmodule
